// [rtl/mode_strap_pin_mux.sv]
/*
  mode strap pin multiplexer: captures the six mode straps at power-on reset,
  then hands each strap pin over to its alternate function once enabled,
  handles hardware standby entry and the byte-lane meaning of lane strobes.
  assumes all inputs are synchronous to I_CORE_CLK and that the board
  resolves each two-way pin from dout and active-low output enable.
*/
module mode_strap_pin_mux (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic [5:0] I_MODE_STRAP,
  input wire logic I_CHIP_ACTIVE_IN,
  input wire strap_mux_pkg::mux_ctrl_t I_MUX_CTRL,
  input wire strap_mux_pkg::alt_func_t I_ALT_FUNC,
  input wire strap_mux_pkg::lane_req_t I_LANE_REQ,
  output logic [5:0] O_MODE_STRAP_DOUT,
  output logic [5:0] O_MODE_STRAP_OE_N,
  output logic O_BIG_ENDIAN,
  output logic [1:0] O_AREA0_BUS_WIDTH,
  output logic O_MODE_VALID,
  output logic O_SERIAL_RXD,
  output logic O_SERIAL_SCK_IN,
  output logic O_HW_STANDBY,
  output strap_mux_pkg::lane_pins_t O_LANE_PINS
);

  ////////////////////////////////////////////////////////////////////////////
  // power-on capture

  // the straps are caught on the first edge after reset release, since an
  // async reset may only load constants; the pins are still inputs then
  logic captured_q;
  logic [5:0] strap_q;
  logic hw_standby_q;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      captured_q <= 1'b0;
      strap_q <= strap_mux_pkg::STRAP_RESET_VALUE;
    end else if (!captured_q) begin
      captured_q <= 1'b1;
      strap_q <= I_MODE_STRAP;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BIG_ENDIAN <= strap_mux_pkg::ENDIAN_RESET;
      O_AREA0_BUS_WIDTH <= strap_mux_pkg::BUS_WIDTH_RESET;
      O_MODE_VALID <= 1'b0;
    end else begin
      O_BIG_ENDIAN <= strap_q[strap_mux_pkg::STRAP_ENDIAN_BIT];
      O_AREA0_BUS_WIDTH <= {strap_q[strap_mux_pkg::STRAP_CE_B_BIT],
                            strap_q[strap_mux_pkg::STRAP_CE_A_BIT]};
      O_MODE_VALID <= captured_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate function enables

  // enables are held off until the straps are captured, so a control word
  // that is already set at release cannot corrupt the mode sample
  strap_mux_pkg::strap_drive_t drive_d;
  logic [5:0] alt_en;

  always_comb begin
    alt_en = 6'h00;
    if (captured_q) begin
      alt_en[strap_mux_pkg::STRAP_ENDIAN_BIT] = I_MUX_CTRL.area2_dram_en;
      alt_en[strap_mux_pkg::STRAP_CE_B_BIT] = I_MUX_CTRL.card_b_en;
      alt_en[strap_mux_pkg::STRAP_CE_A_BIT] = I_MUX_CTRL.card_a_en;
      alt_en[strap_mux_pkg::STRAP_RXD_BIT] = I_MUX_CTRL.serial_en;
      alt_en[strap_mux_pkg::STRAP_TXD_BIT] = I_MUX_CTRL.serial_en;
      alt_en[strap_mux_pkg::STRAP_SCK_BIT] = I_MUX_CTRL.serial_en;
    end
  end

  always_comb begin
    drive_d.dout = 6'h00;
    drive_d.oe_n = 6'h3F;
    // row strobe drives once area 2 DRAM is on, except in standby
    if (alt_en[strap_mux_pkg::STRAP_ENDIAN_BIT]) begin
      drive_d.dout[strap_mux_pkg::STRAP_ENDIAN_BIT] = I_ALT_FUNC.row_strobe_n;
      drive_d.oe_n[strap_mux_pkg::STRAP_ENDIAN_BIT] = 1'b0;
    end
    // card enables drive their enable input as given, low as well as high, or release
    if (alt_en[strap_mux_pkg::STRAP_CE_B_BIT]) begin
      drive_d.dout[strap_mux_pkg::STRAP_CE_B_BIT] = I_ALT_FUNC.card_b_enable_hi_n;
      drive_d.oe_n[strap_mux_pkg::STRAP_CE_B_BIT] = 1'b0;
    end
    if (alt_en[strap_mux_pkg::STRAP_CE_A_BIT]) begin
      drive_d.dout[strap_mux_pkg::STRAP_CE_A_BIT] = I_ALT_FUNC.card_a_enable_hi_n;
      drive_d.oe_n[strap_mux_pkg::STRAP_CE_A_BIT] = 1'b0;
    end
    // receive data is input only, its enable stays high
    if (alt_en[strap_mux_pkg::STRAP_TXD_BIT]) begin
      drive_d.dout[strap_mux_pkg::STRAP_TXD_BIT] = I_ALT_FUNC.txd;
      drive_d.oe_n[strap_mux_pkg::STRAP_TXD_BIT] = 1'b0;
    end
    if (alt_en[strap_mux_pkg::STRAP_SCK_BIT] && I_ALT_FUNC.sck_drive) begin
      drive_d.dout[strap_mux_pkg::STRAP_SCK_BIT] = I_ALT_FUNC.sck_out;
      drive_d.oe_n[strap_mux_pkg::STRAP_SCK_BIT] = 1'b0;
    end
    // standby floats all six strap pins; trades card idle-high for minimum leakage
    if (hw_standby_q) begin
      drive_d.oe_n = 6'h3F;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_MODE_STRAP_DOUT <= 6'h00;
      O_MODE_STRAP_OE_N <= 6'h3F;
    end else begin
      O_MODE_STRAP_DOUT <= drive_d.dout;
      O_MODE_STRAP_OE_N <= drive_d.oe_n;
    end
  end

  // serial inputs read the pin only while serial owns it, else idle high
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SERIAL_RXD <= 1'b1;
      O_SERIAL_SCK_IN <= 1'b1;
    end else begin
      O_SERIAL_RXD <= alt_en[strap_mux_pkg::STRAP_RXD_BIT] ?
                      I_MODE_STRAP[strap_mux_pkg::STRAP_RXD_BIT] : 1'b1;
      O_SERIAL_SCK_IN <= alt_en[strap_mux_pkg::STRAP_SCK_BIT] ?
                         I_MODE_STRAP[strap_mux_pkg::STRAP_SCK_BIT] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hardware standby

  // the board keeps chip active high through reset, so no gating on reset
  // is needed here beyond the reset value itself

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      hw_standby_q <= 1'b0;
    end else begin
      hw_standby_q <= !I_CHIP_ACTIVE_IN;
    end
  end

  assign O_HW_STANDBY = hw_standby_q;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane strobes

  // area 2 DRAM is a 16-bit port, so its low strobes cas_n[1:0] move to the top two lane pins
  strap_mux_pkg::lane_pins_t lanes_d;

  always_comb begin
    if (I_MUX_CTRL.area2_dram_en) begin
      lanes_d.col_strobe_top_lane_n = I_LANE_REQ.cas_n[1];
      lanes_d.col_strobe_second_lane_n = I_LANE_REQ.cas_n[0];
    end else begin
      lanes_d.col_strobe_top_lane_n = I_LANE_REQ.cas_n[3];
      lanes_d.col_strobe_second_lane_n = I_LANE_REQ.cas_n[2];
    end
    // write enable and PCMCIA I/O write share one lane bit; pcmcia_access decides
    if (I_LANE_REQ.pcmcia_access) begin
      lanes_d.lane3_write_mask_n = I_LANE_REQ.io_write_n;
    end else begin
      lanes_d.lane3_write_mask_n = I_LANE_REQ.we_n[3];
    end
    lanes_d.lane0_write_mask_n = I_LANE_REQ.we_n[0];
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_LANE_PINS <= '{strap_mux_pkg::STROBE_IDLE, strap_mux_pkg::STROBE_IDLE,
                       strap_mux_pkg::STROBE_IDLE, strap_mux_pkg::STROBE_IDLE};
    end else begin
      O_LANE_PINS <= lanes_d;
    end
  end

endmodule // mode_strap_pin_mux

// [rtl/strap_mux_pkg.sv]
/*
  package for the mode strap pin multiplexer: strap layout, mode field
  positions, reset values and the carrier structs for the pin groups.
  assumes a single 20 MHz core clock and an active-low async reset.
*/
package strap_mux_pkg;

  localparam int NUM_STRAPS = 6;

  // strap bit positions
  localparam int STRAP_SCK_BIT = 0;
  localparam int STRAP_TXD_BIT = 1;
  localparam int STRAP_RXD_BIT = 2;
  localparam int STRAP_CE_A_BIT = 3;
  localparam int STRAP_CE_B_BIT = 4;
  localparam int STRAP_ENDIAN_BIT = 5;

  localparam logic [5:0] STRAP_RESET_VALUE = 6'h00;
  localparam logic [1:0] BUS_WIDTH_RESET = 2'h0;
  localparam logic ENDIAN_RESET = 1'h0;

  // lane strobe field layout, bit n belongs to data byte lane n
  localparam logic [3:0] LANES_IDLE = 4'hF;
  localparam logic STROBE_IDLE = 1'h1;

  // carriers: a two-way pin is input, output and output enable (low = drive)
  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe_n;
  } strap_drive_t;

  typedef struct packed {
    logic area2_dram_en;
    logic card_a_en;
    logic card_b_en;
    logic serial_en;
  } mux_ctrl_t;

  typedef struct packed {
    logic row_strobe_n;
    logic card_a_enable_hi_n;
    logic card_b_enable_hi_n;
    logic txd;
    logic sck_out;
    logic sck_drive;
  } alt_func_t;

  typedef struct packed {
    logic [3:0] cas_n;
    logic [3:0] we_n;
    logic io_write_n;
    logic pcmcia_access;
    logic sdram_access;
  } lane_req_t;

  typedef struct packed {
    logic col_strobe_top_lane_n;
    logic col_strobe_second_lane_n;
    logic lane3_write_mask_n;
    logic lane0_write_mask_n;
  } lane_pins_t;

endpackage

// [test/strap_board.sv]
/*
  board side of the strap pins: strap resistors against the device drive.
  assumes oe_n low means the device drives the pin.
*/
module strap_board (
  input wire logic [5:0] i_strap,
  input wire logic [5:0] i_dout,
  input wire logic [5:0] i_oe_n,
  output logic [5:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pin falls back to its strap resistor, never the last driven value
  assign o_pin = (i_oe_n & i_strap) | (~i_oe_n & i_dout);
endmodule // strap_board

// [test/strap_mux_chk.sv]
/*
  checker on the top ports of the mode strap pin mux.
  assumes the single core clock and the async active-low reset.
*/
module strap_mux_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic [5:0] I_MODE_STRAP,
  input wire logic I_CHIP_ACTIVE_IN,
  input wire strap_mux_pkg::mux_ctrl_t I_MUX_CTRL,
  input wire strap_mux_pkg::alt_func_t I_ALT_FUNC,
  input wire strap_mux_pkg::lane_req_t I_LANE_REQ,
  input wire logic [5:0] O_MODE_STRAP_DOUT,
  input wire logic [5:0] O_MODE_STRAP_OE_N,
  input wire logic O_BIG_ENDIAN,
  input wire logic [1:0] O_AREA0_BUS_WIDTH,
  input wire logic O_MODE_VALID,
  input wire logic O_SERIAL_RXD,
  input wire logic O_HW_STANDBY,
  input wire strap_mux_pkg::lane_pins_t O_LANE_PINS
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  //////////////////////////////////////////////////////////////////////////////
  // straps are sampled at the first edge after release, shown one edge later
  property p_capture;
    $rose(O_MODE_VALID) |-> {O_BIG_ENDIAN, O_AREA0_BUS_WIDTH} == $past(I_MODE_STRAP[5:3], 1);
  endproperty
  a_capture: assert property (p_capture) else $error("mode capture wrong");
  property p_top;
    $past(I_NRST) |-> O_LANE_PINS.col_strobe_top_lane_n ==
      $past(I_MUX_CTRL.area2_dram_en ? I_LANE_REQ.cas_n[1] : I_LANE_REQ.cas_n[3]);
  endproperty
  a_top: assert property (p_top) else $error("top column strobe wrong");
  property p_second;
    $past(I_NRST) |-> O_LANE_PINS.col_strobe_second_lane_n ==
      $past(I_MUX_CTRL.area2_dram_en ? I_LANE_REQ.cas_n[0] : I_LANE_REQ.cas_n[2]);
  endproperty
  a_second: assert property (p_second) else $error("second column strobe wrong");
  property p_lane3;
    $past(I_NRST) |-> O_LANE_PINS.lane3_write_mask_n ==
      $past(I_LANE_REQ.pcmcia_access ? I_LANE_REQ.io_write_n : I_LANE_REQ.we_n[3]);
  endproperty
  a_lane3: assert property (p_lane3) else $error("lane3 strobe wrong");
  property p_lane0;
    $past(I_NRST) |-> O_LANE_PINS.lane0_write_mask_n == $past(I_LANE_REQ.we_n[0]);
  endproperty
  a_lane0: assert property (p_lane0) else $error("lane0 strobe wrong");
  property p_card_a;
    !O_MODE_STRAP_OE_N[3] |-> $past(I_MUX_CTRL.card_a_en) &&
      O_MODE_STRAP_DOUT[3] == $past(I_ALT_FUNC.card_a_enable_hi_n);
  endproperty
  a_card_a: assert property (p_card_a) else $error("card a pin wrong");
  property p_rxd;
    ($past(I_NRST) && !$past(I_MUX_CTRL.serial_en)) |-> O_SERIAL_RXD &&
      O_MODE_STRAP_OE_N[2];
  endproperty
  a_rxd: assert property (p_rxd) else $error("receive pin wrong");
  property p_standby;
    !I_CHIP_ACTIVE_IN |=> O_HW_STANDBY ##1 O_MODE_STRAP_OE_N == 6'h3F;
  endproperty
  a_standby: assert property (p_standby) else $error("standby entry wrong");
  property p_row;
    !O_MODE_STRAP_OE_N[5] |-> $past(I_MUX_CTRL.area2_dram_en) &&
      O_MODE_STRAP_DOUT[5] == $past(I_ALT_FUNC.row_strobe_n);
  endproperty
  a_row: assert property (p_row) else $error("row strobe pin wrong");
  property p_card_b;
    !O_MODE_STRAP_OE_N[4] |-> $past(I_MUX_CTRL.card_b_en) &&
      O_MODE_STRAP_DOUT[4] == $past(I_ALT_FUNC.card_b_enable_hi_n);
  endproperty
  a_card_b: assert property (p_card_b) else $error("card b pin wrong");
  property p_sck;
    !O_MODE_STRAP_OE_N[0] |-> $past(I_MUX_CTRL.serial_en && I_ALT_FUNC.sck_drive) &&
      O_MODE_STRAP_DOUT[0] == $past(I_ALT_FUNC.sck_out);
  endproperty
  a_sck: assert property (p_sck) else $error("serial clock pin wrong");
  c_standby: cover property ($rose(O_HW_STANDBY));
  c_row: cover property (!O_MODE_STRAP_OE_N[5]);
  c_sck: cover property (!O_MODE_STRAP_OE_N[0]);
endmodule // strap_mux_chk

bind mode_strap_pin_mux strap_mux_chk strap_mux_chk_i (.*);

// [test/tb_mode_strap_pin_mux.sv]
/*
  bench for mode_strap_pin_mux: several resets with random straps, then random
  mux, lane and standby traffic checked through a queue. assumes strap_board.
*/
module tb_mode_strap_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, nrst = 1'h0, ca = 1'h1, sb_m, pend_ok = 1'h0, endian, valid, rxd, sb;
  logic [5:0] strap = 6'h00, st, pin, dout, oe_n;
  logic [1:0] width;
  logic [18:0] q[$], pend, e;
  strap_mux_pkg::mux_ctrl_t ctl = 4'h0;
  strap_mux_pkg::alt_func_t alt = 6'h3F;
  strap_mux_pkg::lane_req_t req = 11'h7FF;
  strap_mux_pkg::lane_pins_t lanes;
  int miscompares = 0, comparisons = 0, seed = 47, n;
  always #25 clk = ~clk;
  strap_board strap_board_i (.i_strap(strap), .i_dout(dout), .i_oe_n(oe_n), .o_pin(pin));
  mode_strap_pin_mux mode_strap_pin_mux_i (.I_CORE_CLK(clk), .I_NRST(nrst), .I_MODE_STRAP(pin),
    .I_CHIP_ACTIVE_IN(ca), .I_MUX_CTRL(ctl), .I_ALT_FUNC(alt), .I_LANE_REQ(req),
    .O_MODE_STRAP_DOUT(dout), .O_MODE_STRAP_OE_N(oe_n), .O_BIG_ENDIAN(endian),
    .O_AREA0_BUS_WIDTH(width), .O_MODE_VALID(valid), .O_SERIAL_RXD(rxd),
    .O_SERIAL_SCK_IN(), .O_HW_STANDBY(sb), .O_LANE_PINS(lanes));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one random cycle; its expectation is queued at the next edge
  task automatic step();
    logic [31:0] w;
    strap_mux_pkg::mux_ctrl_t c;
    strap_mux_pkg::alt_func_t a;
    strap_mux_pkg::lane_req_t r;
    logic [5:0] o;
    logic k;
    logic dc;
    @(posedge clk);
    if (pend_ok) q.push_back(pend);
    w = $random(seed);
    c = w[3:0];
    a = w[9:4];
    r = w[20:10];
    k = w[23:21] != 3'h0;
    dc = 1'h0; // receive path is not gated by standby, so it is checked exactly
    o = sb_m ? 6'h3F : {~c.area2_dram_en, ~c.card_b_en, ~c.card_a_en, 1'h1, ~c.serial_en,
      ~(c.serial_en & a.sck_drive)};
    pend = {o, o | {a.row_strobe_n, a.card_b_enable_hi_n, a.card_a_enable_hi_n, 1'h1, a.txd,
      a.sck_out}, c.area2_dram_en ? r.cas_n[1] : r.cas_n[3],
      c.area2_dram_en ? r.cas_n[0] : r.cas_n[2], r.pcmcia_access ? r.io_write_n : r.we_n[3],
      r.we_n[0], ~k, dc | ~c.serial_en | w[26], dc};
    ctl <= c;
    alt <= a;
    req <= r;
    ca <= k;
    strap <= w[29:24];
    sb_m = ~k;
    pend_ok = 1'h1;
  endtask
  task automatic boot(input logic [5:0] s);
    pend_ok = 1'h0;
    @(negedge clk);
    @(posedge clk);
    nrst <= 1'h0;
    ca <= 1'h1;
    ctl <= 4'h0;
    strap <= s;
    st = s;
    sb_m = 1'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    for (n = 0; n < 8 && valid !== 1'h1; n++) @(negedge clk);
    if (valid !== 1'h1) begin
      miscompares++;
      summarize();
    end
    chk({15'h0, endian, width}, {15'h0, s[5:3]});
  endtask
  always @(negedge clk) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      chk({oe_n, dout | oe_n, lanes, sb, rxd | e[0]}, e[18:1]);
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(6'($random(seed)));
      repeat (300) step();
      chk({15'h0, endian, width}, {15'h0, st[5:3]});
    end
    repeat (2) @(negedge clk);
    summarize();
  end
endmodule // tb_mode_strap_pin_mux
